// File: core/fss_pkg.sv
// Shared constants, field layouts and types of the flicker severity scheduler
package fss_pkg;
  // Phase count and data widths
  localparam int NPH = 3;
  localparam int DW = 16;
  localparam int TW = 32;
  // Interval limits in minutes
  localparam logic [3:0] ST_MIN = 4'h1;
  localparam logic [3:0] ST_MAX = 4'hA;
  localparam logic [3:0] ST_DEF = 4'hA;
  localparam logic [7:0] LT_MAX = 8'hF0;
  localparam logic [7:0] LT_DEF = 8'h78; // Twelve short intervals of ten minutes
  // Reference voltages in volts
  localparam logic [15:0] REFV_50 = 16'h00E6;
  localparam logic [15:0] REFV_60 = 16'h0078;
  // Perceptibility threshold, unsigned Q8.8
  localparam logic [15:0] PU_ONE = 16'h0100;
  localparam logic [15:0] EXT_MIN_INIT = 16'hFFFF;
  localparam logic [15:0] EXT_MAX_INIT = 16'h0000;
  // Percentile weights, Q0.16: 0.0314 0.0525 0.0657 0.28 0.08
  localparam logic [4:0][15:0] PST_W = {16'h147B, 16'h47AE, 16'h10D2, 16'h0D71, 16'h080A};
  localparam int WSUM_SHIFT = 8;
  // Root engine
  localparam logic [3:0] ROOT_TOP = 4'hF;
  localparam logic [1:0] PH_LAST = 2'h2;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CDOWN = 8'h0C;
  localparam logic [7:0] OFS_T_START = 8'h10;
  localparam logic [7:0] OFS_T_STOP = 8'h14;
  localparam logic [7:0] OFS_T_RST = 8'h18;
  localparam logic [7:0] OFS_T_PST = 8'h1C;
  localparam logic [7:0] OFS_T_PLT = 8'h20;
  localparam logic [7:0] OFS_FREQ = 8'h24;
  localparam logic [7:0] OFS_REFV = 8'h28;
  localparam logic [3:0] GRP_INST = 4'h3;
  localparam logic [3:0] GRP_PST = 4'h4;
  localparam logic [3:0] GRP_PLT = 4'h5;
  localparam logic [3:0] GRP_PST_EXT = 4'h6;
  localparam logic [3:0] GRP_PLT_EXT = 4'h7;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RESET = 2;
  localparam int CFG_ST_LSB = 0;
  localparam int CFG_LT_LSB = 8;
  localparam int CFG_F60 = 16;
  localparam int STAT_ABOVE_LSB = 2;
  localparam int CD_LT_LSB = 16;
  // Log record kinds
  localparam logic [2:0] LOG_START = 3'h1;
  localparam logic [2:0] LOG_STOP = 3'h2;
  localparam logic [2:0] LOG_RESET = 3'h3;
  localparam logic [2:0] LOG_PST = 3'h4;
  localparam logic [2:0] LOG_PLT = 3'h5;

  typedef struct packed {
    logic f60;
    logic [7:0] lt;
    logic [3:0] st;
  } fss_cfg_s;

  typedef struct packed {
    logic [15:0] max;
    logic [15:0] min;
  } fss_ext_s;

  typedef struct packed {
    logic [4:0][15:0] p;
  } fss_pct_s;

  typedef struct packed {
    logic [2:0] kind;
    logic [1:0] phase;
    logic new_max;
    logic new_min;
    logic [15:0] value;
    logic [31:0] stamp;
  } fss_log_s;

  typedef struct packed {
    fss_cfg_s cfg;
    logic run;
    fss_ext_s [2:0] pst_ext;
    fss_ext_s [2:0] plt_ext;
  } fss_nv_s;

  typedef enum logic [3:0] {
    FSS_IDLE = 4'b0001,
    FSS_WAIT = 4'b0010,
    FSS_ROOT = 4'b0100,
    FSS_DONE = 4'b1000
  } fss_state_e;
endpackage

// File: core/fss_scheduler.sv
// Flicker severity scheduler: intervals, roots, extremes, log, APB registers
`timescale 1ns/10ps
module fss_scheduler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Real-time clock
  input wire logic rtc_min_tick,
  input wire logic [10:0] rtc_minute,
  input wire logic [31:0] rtc_time,
  // Front end
  input wire logic [2:0][15:0] pinst_in,
  input wire logic [2:0][15:0] volt_in,
  input wire logic [15:0] freq_in,
  output logic [15:0] ref_volt,
  output logic run,
  // Level classifier
  input wire logic cls_valid,
  input wire fss_pkg::fss_pct_s cls_pct,
  output logic cls_ready,
  output logic [1:0] cls_phase,
  // Log
  output logic log_stb,
  output fss_pkg::fss_log_s log_rec,
  // Non-volatile store
  input wire logic nv_restore_valid,
  input wire fss_pkg::fss_nv_s nv_restore,
  output logic nv_wr,
  output fss_pkg::fss_nv_s nv_img
);

  fss_pkg::fss_cfg_s cfg_r;
  fss_pkg::fss_state_e state_r;
  fss_pkg::fss_ext_s [2:0] pst_ext_r;
  fss_pkg::fss_ext_s [2:0] plt_ext_r;
  fss_pkg::fss_log_s log_r;
  fss_pkg::fss_nv_s nv_prev_r;
  logic run_r;
  logic [31:0] t_start_r, t_stop_r, t_rst_r, t_pst_r, t_plt_r;
  logic [2:0][15:0] pinst_r, volt_r, pst_r, plt_r;
  logic [15:0] freq_r;
  logic [3:0] st_pos_r;
  logic [7:0] lt_pos_r;
  logic pend_st_r, pend_lt_r, lt_mode_r, log_stb_r, nv_wr_r;
  logic [1:0] ph_r;
  logic [15:0] root_r;
  logic [3:0] bit_r;
  logic [55:0] rad_r;
  logic [2:0][55:0] sum_r;
  logic [7:0] n_r;
  logic [31:0] prdata_r;

  // Config check: one multiplier per quotient, tolerable for a write-time test
  function automatic logic cfg_ok(input logic [3:0] st, input logic [7:0] lt);
    logic ok;
    ok = 1'b0;
    for (int k = 1; k <= 240; k++)
    begin
      if (16'(k) * 16'(st) == 16'(lt))
        ok = 1'b1;
    end
    return ok && st >= fss_pkg::ST_MIN && st <= fss_pkg::ST_MAX && lt <= fss_pkg::LT_MAX;
  endfunction

  // Word address decode used by read and error paths
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && ((a <= fss_pkg::OFS_REFV) ||
      (a[7:4] >= fss_pkg::GRP_INST && a[7:4] <= fss_pkg::GRP_PLT_EXT && a[3:2] <= fss_pkg::PH_LAST));
  endfunction

  // Bus decode
  logic wr_acc, cmd_start, cmd_stop, cmd_reset, any_cmd, restart, cfg_wr, cfg_good;
  assign wr_acc = psel && penable && pwrite;
  assign cmd_start = wr_acc && paddr == fss_pkg::OFS_CTRL && pwdata[fss_pkg::CTRL_START];
  assign cmd_stop = wr_acc && paddr == fss_pkg::OFS_CTRL && pwdata[fss_pkg::CTRL_STOP];
  assign cmd_reset = wr_acc && paddr == fss_pkg::OFS_CTRL && pwdata[fss_pkg::CTRL_RESET];
  assign any_cmd = cmd_start || cmd_stop || cmd_reset;
  assign restart = (cmd_start || cmd_reset) && !cmd_stop;
  assign cfg_good = cfg_ok(pwdata[fss_pkg::CFG_ST_LSB +: 4], pwdata[fss_pkg::CFG_LT_LSB +: 8]);
  assign cfg_wr = wr_acc && paddr == fss_pkg::OFS_CFG;

  // Zero-wait access; read data was captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = psel && penable && (!addr_mapped(paddr) || (cfg_wr && !cfg_good));

  // Settings: out-of-range intervals are refused, old values stay
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_r <= '{f60: 1'b0, lt: fss_pkg::LT_DEF, st: fss_pkg::ST_DEF};
    else if (nv_restore_valid && cfg_ok(nv_restore.cfg.st, nv_restore.cfg.lt))
      cfg_r <= nv_restore.cfg;
    else if (cfg_wr && cfg_good)
      cfg_r <= '{f60: pwdata[fss_pkg::CFG_F60], lt: pwdata[fss_pkg::CFG_LT_LSB +: 8],
                 st: pwdata[fss_pkg::CFG_ST_LSB +: 4]};
  end

  // Reference voltage handed to the gain stage
  assign ref_volt = cfg_r.f60 ? fss_pkg::REFV_60 : fss_pkg::REFV_50;

  // Run state; stop wins over start in one write; restored after power loss
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      run_r <= 1'b0;
    else if (nv_restore_valid)
      run_r <= nv_restore.run;
    else if (cmd_stop)
      run_r <= 1'b0;
    else if (cmd_start)
      run_r <= 1'b1;
  end
  assign run = run_r;

  // Event timestamps
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t_start_r <= '0;
      t_stop_r <= '0;
      t_rst_r <= '0;
    end
    else
    begin
      if (cmd_start && !cmd_stop)
        t_start_r <= rtc_time;
      if (cmd_stop)
        t_stop_r <= rtc_time;
      if (any_cmd)
        t_rst_r <= rtc_time;
    end
  end

  // Live inputs; levels and voltages held frozen while stopped, frequency sampled every cycle. Frequency mismatch is not checked.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinst_r <= '0;
      volt_r <= '0;
      freq_r <= '0;
    end
    else
    begin
      freq_r <= freq_in;
      if (run_r)
      begin
        pinst_r <= pinst_in;
        volt_r <= volt_in;
      end
    end
  end

  // Positions taken from the minute of day, so boundaries sit on clock marks and the first interval may be short
  logic st_bnd, lt_bnd;
  assign st_bnd = rtc_min_tick && rtc_minute % 11'(cfg_r.st) == 11'h000;
  assign lt_bnd = rtc_min_tick && rtc_minute % 11'(cfg_r.lt) == 11'h000;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_pos_r <= '0;
      lt_pos_r <= '0;
    end
    else if (rtc_min_tick)
    begin
      st_pos_r <= 4'(rtc_minute % 11'(cfg_r.st));
      lt_pos_r <= 8'(rtc_minute % 11'(cfg_r.lt));
    end
  end

  // Root engine: one result bit per cycle, shared by square and cube roots
  logic [15:0] trial;
  logic [47:0] t_pow;
  logic [55:0] t_cmp;
  logic [34:0] wsum;
  logic commit, last_ph;
  assign trial = root_r | (16'h0001 << bit_r);
  assign t_pow = lt_mode_r ? 48'(trial) * 48'(trial) * 48'(trial) : 48'(32'(trial) * 32'(trial));
  assign t_cmp = lt_mode_r ? 56'(t_pow) * 56'(n_r) : 56'(t_pow);
  assign commit = state_r == fss_pkg::FSS_DONE && !any_cmd;
  assign last_ph = ph_r == fss_pkg::PH_LAST;
  assign cls_ready = state_r == fss_pkg::FSS_WAIT;
  assign cls_phase = ph_r;

  // Weighted percentile sum from the classifier
  always_comb
  begin
    wsum = '0;
    for (int k = 0; k < 5; k++)
      wsum = wsum + 35'(fss_pkg::PST_W[k]) * 35'(cls_pct.p[k]);
  end

  // Work pending from boundaries; a new boundary wins over completion
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_st_r <= 1'b0;
      pend_lt_r <= 1'b0;
    end
    else if (any_cmd)
    begin
      pend_st_r <= 1'b0;
      pend_lt_r <= 1'b0;
    end
    else
    begin
      if (st_bnd && run_r)
        pend_st_r <= 1'b1;
      else if (commit && last_ph && !lt_mode_r)
        pend_st_r <= 1'b0;
      if (lt_bnd && run_r)
        pend_lt_r <= 1'b1;
      else if ((commit && last_ph && lt_mode_r) ||
               (state_r == fss_pkg::FSS_IDLE && !pend_st_r && n_r == 8'h00))
        pend_lt_r <= 1'b0;
    end
  end

  // Sequencer over the three phases
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= fss_pkg::FSS_IDLE;
      ph_r <= '0;
      lt_mode_r <= 1'b0;
      root_r <= '0;
      bit_r <= '0;
      rad_r <= '0;
    end
    else if (any_cmd)
      state_r <= fss_pkg::FSS_IDLE;
    else
    begin
      case (state_r)
        fss_pkg::FSS_IDLE:
        begin
          ph_r <= '0;
          root_r <= '0;
          bit_r <= fss_pkg::ROOT_TOP;
          if (pend_st_r)
          begin
            lt_mode_r <= 1'b0;
            state_r <= fss_pkg::FSS_WAIT;
          end
          else if (pend_lt_r && n_r != 8'h00)
          begin
            lt_mode_r <= 1'b1;
            rad_r <= sum_r[0];
            state_r <= fss_pkg::FSS_ROOT;
          end
        end
        fss_pkg::FSS_WAIT:
        begin
          if (cls_valid)
          begin
            rad_r <= 56'(wsum[34:fss_pkg::WSUM_SHIFT]);
            state_r <= fss_pkg::FSS_ROOT;
          end
        end
        fss_pkg::FSS_ROOT:
        begin
          if (t_cmp <= rad_r)
            root_r <= trial;
          if (bit_r == 4'h0)
            state_r <= fss_pkg::FSS_DONE;
          else
            bit_r <= bit_r - 4'h1;
        end
        fss_pkg::FSS_DONE:
        begin
          root_r <= '0;
          bit_r <= fss_pkg::ROOT_TOP;
          if (last_ph)
            state_r <= fss_pkg::FSS_IDLE;
          else
          begin
            ph_r <= ph_r + 2'h1;
            rad_r <= sum_r[ph_r + 2'h1];
            state_r <= lt_mode_r ? fss_pkg::FSS_ROOT : fss_pkg::FSS_WAIT;
          end
        end
        default:
          state_r <= fss_pkg::FSS_IDLE;
      endcase
    end
  end

  // Sum of cubes per phase and count of completed short intervals in the long period
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sum_r <= '0;
      n_r <= '0;
    end
    else if (restart)
    begin
      sum_r <= '0;
      n_r <= '0;
    end
    else if (commit && lt_mode_r)
    begin
      sum_r[ph_r] <= '0;
      if (last_ph)
        n_r <= '0;
    end
    else if (commit)
    begin
      sum_r[ph_r] <= sum_r[ph_r] + 56'(48'(root_r) * 48'(root_r) * 48'(root_r));
      if (last_ph)
        n_r <= n_r + 8'h01;
    end
  end

  // Results with computation stamps
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pst_r <= '0;
      plt_r <= '0;
      t_pst_r <= '0;
      t_plt_r <= '0;
    end
    else if (commit && lt_mode_r)
    begin
      plt_r[ph_r] <= root_r;
      t_plt_r <= rtc_time;
    end
    else if (commit)
    begin
      pst_r[ph_r] <= root_r;
      t_pst_r <= rtc_time;
    end
  end

  // Extremes: cleared by any command, updated on each result, restored at power-up
  logic new_max, new_min;
  fss_pkg::fss_ext_s cur_ext;
  assign cur_ext = lt_mode_r ? plt_ext_r[ph_r] : pst_ext_r[ph_r];
  assign new_max = root_r > cur_ext.max;
  assign new_min = root_r < cur_ext.min;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pst_ext_r <= {3{fss_pkg::EXT_MAX_INIT, fss_pkg::EXT_MIN_INIT}};
      plt_ext_r <= {3{fss_pkg::EXT_MAX_INIT, fss_pkg::EXT_MIN_INIT}};
    end
    else if (nv_restore_valid)
    begin
      pst_ext_r <= nv_restore.pst_ext;
      plt_ext_r <= nv_restore.plt_ext;
    end
    else if (any_cmd)
    begin
      pst_ext_r <= {3{fss_pkg::EXT_MAX_INIT, fss_pkg::EXT_MIN_INIT}};
      plt_ext_r <= {3{fss_pkg::EXT_MAX_INIT, fss_pkg::EXT_MIN_INIT}};
    end
    else if (commit)
    begin
      if (lt_mode_r)
        plt_ext_r[ph_r] <= '{max: new_max ? root_r : cur_ext.max, min: new_min ? root_r : cur_ext.min};
      else
        pst_ext_r[ph_r] <= '{max: new_max ? root_r : cur_ext.max, min: new_min ? root_r : cur_ext.min};
    end
  end

  // Log port: commands outrank results, which the sequencer then drops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      log_stb_r <= 1'b0;
      log_r <= '0;
    end
    else
    begin
      log_stb_r <= (any_cmd && (run_r || cmd_start)) || (commit && run_r);
      if (any_cmd)
        log_r <= '{kind: cmd_stop ? fss_pkg::LOG_STOP : cmd_start ? fss_pkg::LOG_START : fss_pkg::LOG_RESET,
                   phase: 2'h0, new_max: 1'b0, new_min: 1'b0, value: 16'h0000, stamp: rtc_time};
      else if (commit)
        log_r <= '{kind: lt_mode_r ? fss_pkg::LOG_PLT : fss_pkg::LOG_PST, phase: ph_r,
                   new_max: new_max, new_min: new_min, value: root_r, stamp: rtc_time};
    end
  end
  assign log_stb = log_stb_r;
  assign log_rec = log_r;

  // Persistent image; write pulse one cycle after any change
  assign nv_img = '{cfg: cfg_r, run: run_r, pst_ext: pst_ext_r, plt_ext: plt_ext_r};
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nv_prev_r <= '0;
      nv_wr_r <= 1'b0;
    end
    else
    begin
      nv_prev_r <= nv_img;
      nv_wr_r <= nv_img != nv_prev_r;
    end
  end
  assign nv_wr = nv_wr_r;

  // Read mux, sampled in the setup cycle
  logic [31:0] rd_word;
  logic [1:0] rph;
  logic [2:0] above;
  assign rph = paddr[3:2];
  always_comb
  begin
    for (int i = 0; i < fss_pkg::NPH; i++)
      above[i] = pinst_r[i] >= fss_pkg::PU_ONE;
    rd_word = 32'h0000_0000;
    case (paddr[7:4])
      fss_pkg::GRP_INST: rd_word = {volt_r[rph], pinst_r[rph]};
      fss_pkg::GRP_PST: rd_word = {16'h0000, pst_r[rph]};
      fss_pkg::GRP_PLT: rd_word = {16'h0000, plt_r[rph]};
      fss_pkg::GRP_PST_EXT: rd_word = pst_ext_r[rph];
      fss_pkg::GRP_PLT_EXT: rd_word = plt_ext_r[rph];
      default:
      begin
        case (paddr)
          fss_pkg::OFS_CFG: rd_word = 32'({cfg_r.f60, cfg_r.lt, 4'h0, cfg_r.st});
          fss_pkg::OFS_STAT: rd_word = 32'({above, 1'b0, run_r});
          fss_pkg::OFS_CDOWN: rd_word = {8'h00, cfg_r.lt - lt_pos_r, 12'h000, cfg_r.st - st_pos_r};
          fss_pkg::OFS_T_START: rd_word = t_start_r;
          fss_pkg::OFS_T_STOP: rd_word = t_stop_r;
          fss_pkg::OFS_T_RST: rd_word = t_rst_r;
          fss_pkg::OFS_T_PST: rd_word = t_pst_r;
          fss_pkg::OFS_T_PLT: rd_word = t_plt_r;
          fss_pkg::OFS_FREQ: rd_word = {16'h0000, freq_r};
          fss_pkg::OFS_REFV: rd_word = {16'h0000, ref_volt};
          default: rd_word = 32'h0000_0000;
        endcase
      end
    endcase
    if (!addr_mapped(paddr))
      rd_word = 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata_r <= '0;
    else if (psel && !penable && !pwrite)
      prdata_r <= rd_word;
  end

  // Cycles spent in the current root pass; a counter keeps the length check cheap
  logic [4:0] root_cnt_r;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      root_cnt_r <= '0;
    else if (state_r == fss_pkg::FSS_ROOT)
      root_cnt_r <= root_cnt_r + 5'h01;
    else
      root_cnt_r <= '0;
  end

  // Checks
  a_cfg_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_r.st >= fss_pkg::ST_MIN && cfg_r.st <= fss_pkg::ST_MAX) else $error("short interval out of range");
  a_lt_bound: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_r.lt >= 8'(cfg_r.st) && cfg_r.lt <= fss_pkg::LT_MAX) else $error("long interval out of range");
  a_stop_halts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_stop && !nv_restore_valid |=> !run_r && state_r == fss_pkg::FSS_IDLE) else $error("stop did not halt");
  a_start_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_start && !nv_restore_valid |=> pst_ext_r[0].max == fss_pkg::EXT_MAX_INIT && n_r == 8'h00)
    else $error("start did not clear");
  a_root_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_r == fss_pkg::FSS_DONE |-> root_cnt_r == 5'(fss_pkg::ROOT_TOP) + 5'h01) else $error("root length wrong");
  a_ext_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
    commit && !lt_mode_r && !nv_restore_valid |=> pst_ext_r[$past(ph_r)].max >= pst_r[$past(ph_r)] &&
    pst_ext_r[$past(ph_r)].min <= pst_r[$past(ph_r)]) else $error("extremes not tracked");
  a_ref_volt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ref_volt == (cfg_r.f60 ? 16'h0078 : 16'h00E6)) else $error("reference voltage wrong");
  a_log_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    log_stb && log_rec.kind == fss_pkg::LOG_PST |-> $past(run_r)) else $error("result logged while stopped");
  a_countdown: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rtc_min_tick && !cfg_wr && !nv_restore_valid |=> st_pos_r < cfg_r.st && (st_pos_r == 4'h0) == $past(st_bnd))
    else $error("countdown did not step");
endmodule

// File: dv/fss_front_model.sv
// Front-end model: minute clock and level classifier
`timescale 1ns/10ps
module fss_front_model #(
  parameter int MIN_CYC = 40
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Minute clock
  output logic rtc_min_tick,
  output logic [10:0] rtc_minute,
  output logic [31:0] rtc_time,
  // Classifier beat
  input wire logic cls_ready,
  output logic cls_valid,
  output fss_pkg::fss_pct_s cls_pct
);
  int cnt;
  // Minutes shortened to keep the run brief; odd start minute
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 0;
      rtc_min_tick <= 1'b0;
      rtc_minute <= 11'h003;
      rtc_time <= 32'h0000_0100;
    end
    else
    begin
      cnt <= (cnt == MIN_CYC - 1) ? 0 : cnt + 1;
      rtc_min_tick <= (cnt == MIN_CYC - 1);
      if (cnt == MIN_CYC - 1)
      begin
        rtc_minute <= (rtc_minute == 11'h59F) ? 11'h000 : rtc_minute + 11'h001;
        rtc_time <= rtc_time + 32'h0000_0001;
      end
    end
  end
  // Slow classifier: beat every other cycle, junk in between
  assign cls_valid = cnt[0];
  assign cls_pct = cnt[0] ? {5{16'h0200}} : {5{16'hFDFF}};
endmodule

// File: dv/tb.sv
// Testbench of the flicker severity scheduler over APB
`timescale 1ns/10ps
module tb;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, run, nv_rv;
  logic cls_valid, cls_ready, rtc_min_tick, log_stb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rtc_time, ts, q;
  logic [10:0] rtc_minute;
  logic [15:0] ref_volt;
  logic [1:0] cls_phase;
  logic [2:0][15:0] pinst_in, volt_in;
  fss_pkg::fss_pct_s cls_pct;
  fss_pkg::fss_log_s log_rec;
  fss_pkg::fss_nv_s nv_restore;
  logic [31:0] bad [5] = '{32'h0001_1400, 32'h0001_160B, 32'h0001_F505, 32'h0001_1605, 32'h0001_0305};
  int n_mismatch = 0;
  int n_tests = 0;
  int n_pst = 0;
  int n_plt = 0;
  // Root of the weighted sum of 2.00 percentiles, Q8.8; also the long result of equal shorts
  localparam logic [15:0] PST_EXP = 16'h0102;

  fss_scheduler uut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rtc_min_tick, .rtc_minute, .rtc_time, .pinst_in, .volt_in, .freq_in(16'h01F4),
    .ref_volt, .run, .cls_valid, .cls_pct, .cls_ready, .cls_phase, .log_stb, .log_rec,
    .nv_restore_valid(nv_rv), .nv_restore, .nv_wr(), .nv_img());
  fss_front_model front (.sys_clk, .rst_b, .rtc_min_tick, .rtc_minute, .rtc_time, .cls_ready,
    .cls_valid, .cls_pct);

  // 250 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Count short and long results leaving on the log
  always @(posedge sys_clk)
  begin
    if (log_stb === 1'b1 && log_rec.kind === fss_pkg::LOG_PST)
      n_pst++;
    if (log_stb === 1'b1 && log_rec.kind === fss_pkg::LOG_PLT)
      n_plt++;
  end

  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; stamp is the minute clock at the access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    ts = rtc_time;
    chk({31'h0, pslverr}, {31'h0, e}, "error response");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e = 1'b0);
    apb(1'b0, a, 32'h0000_0000, e);
    chk(q, x, "read data");
  endtask

  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    nv_rv = 1'b0;
    nv_restore = '0;
    pinst_in = {16'h00FF, 16'h0100, 16'h00FF};
    volt_in = {16'h0070, 16'h0072, 16'h0074};
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(fss_pkg::OFS_CFG, 32'h0000_780A);
    rd(fss_pkg::OFS_REFV, 32'h0000_00E6);
    rd(fss_pkg::OFS_FREQ, 32'h0000_01F4);
    rd(8'hFC, 32'h0000_0000, 1'b1);
    apb(1'b1, fss_pkg::OFS_CFG, 32'h0001_1405, 1'b0);
    rd(fss_pkg::OFS_REFV, 32'h0000_0078);
    chk({16'h0, ref_volt}, 32'h0000_0078, "gain reference");
    foreach (bad[i])
      apb(1'b1, fss_pkg::OFS_CFG, bad[i], 1'b1);
    rd(fss_pkg::OFS_CFG, 32'h0001_1405);
    apb(1'b1, fss_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    rd(fss_pkg::OFS_T_START, ts);
    rd(fss_pkg::OFS_STAT, 32'h0000_0009);
    rd(8'h34, {volt_in[1], pinst_in[1]});
    apb(1'b0, fss_pkg::OFS_CDOWN, 32'h0000_0000, 1'b0);
    chk(32'(q[3:0] >= 4'h1 && q[3:0] <= 4'h5), 32'h1, "short countdown");
    for (int i = 0; i < 3000 && n_pst < 3; i++)
      @(posedge sys_clk);
    chk(n_pst, 3, "short results logged");
    rd(8'h40, {16'h0000, PST_EXP});
    rd(8'h60, {PST_EXP, PST_EXP});
    for (int i = 0; i < 3000 && n_plt < 3; i++)
      @(posedge sys_clk);
    chk(n_plt, 3, "long results logged");
    rd(8'h58, {16'h0000, PST_EXP});
    rd(8'h78, {PST_EXP, PST_EXP});
    apb(1'b1, fss_pkg::OFS_CTRL, 32'h0000_0004, 1'b0);
    rd(fss_pkg::OFS_T_RST, ts);
    rd(8'h60, 32'h0000_FFFF);
    apb(1'b1, fss_pkg::OFS_CTRL, 32'h0000_0002, 1'b0);
    rd(fss_pkg::OFS_T_STOP, ts);
    rd(fss_pkg::OFS_STAT, 32'h0000_0008);
    pinst_in[1] <= 16'h0200;
    repeat (400) @(posedge sys_clk);
    rd(8'h40, {16'h0000, PST_EXP});
    rd(8'h34, 32'h0072_0100);
    nv_restore.run <= 1'b1;
    nv_restore.cfg <= '{1'b0, 8'h78, 4'hA};
    nv_restore.pst_ext[0] <= '{16'h0123, 16'h0045};
    nv_rv <= 1'b1;
    @(posedge sys_clk);
    nv_rv <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, run}, 32'h0000_0001, "resume after power");
    rd(8'h60, 32'h0123_0045);
    tally_and_finish;
  end
endmodule
